// >>> inc/strap_misc_defines.svh
// Constants for the strap, reset and user I/O block.
`ifndef STRAP_MISC_DEFINES_SVH
`define STRAP_MISC_DEFINES_SVH
`define NUM_CS 4
`define USER_W 8
`define ADDR_W 32
`define ADDR_TOP_HI 31
`define ADDR_TOP_LO 24
`define REMAP_BASE 32'h0000_0000
`define SRAM_W8 2'h0
`define SRAM_W16 2'h1
`define SRAM_W32 2'h2
`define SRAM_WRSV 2'h3
`define RST_SYNC_STAGES 2
`endif

// >>> inc/strap_misc_pkg.sv
// Types shared by the strap, reset and user I/O block.
package strap_misc_pkg;
    typedef enum logic [1:0] {
        width_8 = 2'h0,
        width_16 = 2'h1,
        width_32 = 2'h2,
        width_rsv = 2'h3
    } mem_width_e;
    typedef enum logic [1:0] {
        nand_idle = 2'h0,
        nand_addr = 2'h1,
        nand_data = 2'h3
    } nand_phase_e;
endpackage

// >>> hw/static_mem_strap_and_misc_io.sv
// Straps, reset synchronisers, user I/O, interrupts and test overrides of a static memory port.
// ****************************************************************************
// ****************************************************************************
`include "strap_misc_defines.svh"

module static_mem_strap_and_misc_io
    import strap_misc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic mem_if0_clk,
    input wire logic mem_if0_clk_inv,
    input wire logic mem_if0_rst_low,
    input wire logic reg_clk_en,
    input wire logic lp_clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic lp_req,
    input wire logic mux_mode_strap,
    input wire logic remap_strap,
    input wire logic is_flash_if,
    input wire logic [1:0] boot_width_strap_static,
    input wire logic boot_width_strap_flash,
    input wire logic nand_cs_hold_strap,
    input wire logic ecc_present,
    input wire logic [31:0] sys_addr,
    input wire logic [31:0] addr_mask_straps,
    input wire logic [31:0] addr_match_straps,
    input wire logic bus_side_sync_strap,
    input wire logic mem_side_sync_strap,
    input wire logic bus_faster_sync_strap,
    input wire logic ext_bus_strap,
    input wire logic mem_event,
    input wire logic ecc_event,
    input wire logic nand_start,
    input wire logic nand_addr_done,
    input wire logic nand_data_done,
    input wire logic [7:0] user_status,
    input wire logic test_clk_override,
    input wire logic rst_bypass,
    output logic bus_rst_n,
    output logic mem_rst_n,
    output logic shared_addr_data,
    output logic cs0_at_zero,
    output logic [1:0] cs0_width,
    output logic cs0_width_rsv,
    output logic [3:0] cs_hit,
    output logic sync_bypass_bus,
    output logic sync_bypass_mem,
    output logic bus_fast_sync,
    output logic ebi_in_use,
    output logic lp_ack,
    output logic mem_irq,
    output logic ecc_irq,
    output logic combined_irq,
    output logic nand_cs_active,
    output logic [7:0] user_config,
    output logic [7:0] user_status_rd,
    output logic mem_clk_out
);

    // ************************************************************************
    // Reset synchronisers
    // ************************************************************************
    logic [1:0] bus_rst_sync;
    logic [1:0] mem_rst_sync;
    logic [1:0] next_bus_rst_sync;
    logic [1:0] next_mem_rst_sync;
    logic bus_rst_eff;
    logic mem_rst_eff;

    // Shift a one through each two-stage chain; only stage one feeds stage two.
    // The low reset clears a chain at once, while its release needs two clean edges
    // in its own domain, so no flop downstream sees the release near its clock edge.
    always_comb begin
        next_bus_rst_sync = {bus_rst_sync[0], 1'b1};
        next_mem_rst_sync = {mem_rst_sync[0], 1'b1};
    end

    // Bus domain chain, asserted asynchronously by the low reset.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rst_sync <= 2'h0;
        end else begin
            bus_rst_sync <= next_bus_rst_sync;
        end
    end

    // Memory domain chain, asserted asynchronously by its own low reset.
    always_ff @(posedge mem_if0_clk or negedge mem_if0_rst_low) begin
        if (!mem_if0_rst_low) begin
            mem_rst_sync <= 2'h0;
        end else begin
            mem_rst_sync <= next_mem_rst_sync;
        end
    end

    // Bypass selects the raw reset for scan, so the pattern tool controls the resets
    // directly; in normal use the bypass input is tied low.
    assign bus_rst_eff = rst_bypass ? arst_n : bus_rst_sync[1];
    assign mem_rst_eff = rst_bypass ? mem_if0_rst_low : mem_rst_sync[1];

    // ************************************************************************
    // Bus domain registered outputs
    // ************************************************************************
    logic [7:0] next_user_config;
    logic [7:0] next_user_status_rd;
    logic next_lp_ack;
    logic next_mem_irq;
    logic next_ecc_irq;
    logic next_combined_irq;
    logic [3:0] next_cs_hit;
    logic [1:0] next_cs0_width;
    logic next_cs0_width_rsv;
    logic next_cs0_at_zero;
    logic next_shared_addr_data;
    logic next_sync_bypass_bus;
    logic next_bus_fast_sync;
    logic next_ebi_in_use;
    logic next_bus_rst_n;
    logic [3:0] select_match;

    // Per-select decode: the mask gates the top address byte before the base compare.
    for (genvar g = 0; g < `NUM_CS; g++) begin : g_select_decode
        assign select_match[g] = (sys_addr[`ADDR_TOP_HI:`ADDR_TOP_LO]
            & addr_mask_straps[g*8 +: 8]) == addr_match_straps[g*8 +: 8];
    end

    // User I/O under the register enable; the low-power ack under its own enable.
    always_comb begin
        next_user_config = user_config;
        next_user_status_rd = user_status_rd;
        next_lp_ack = lp_ack;
        if (reg_clk_en) begin
            if (reg_wr) begin
                next_user_config = reg_wdata;
            end
            next_user_status_rd = user_status;
        end
        if (lp_clk_en) begin
            next_lp_ack = lp_req;
        end
    end

    // Interrupts; the error-correction line exists only for a flash port with the block.
    always_comb begin
        next_mem_irq = mem_event;
        next_ecc_irq = ecc_event & ecc_present & is_flash_if;
        next_combined_irq = next_mem_irq | next_ecc_irq;
    end

    // Boot width of select 0, select decode and the plain strap copies.
    always_comb begin
        if (is_flash_if) begin
            next_cs0_width = boot_width_strap_flash ? `SRAM_W16 : `SRAM_W8;
        end else begin
            next_cs0_width = boot_width_strap_static;
        end
        next_cs0_width_rsv = !is_flash_if && (boot_width_strap_static == `SRAM_WRSV);
        // Remap makes select 0 answer at the remap base as well as at its own base.
        next_cs_hit = select_match;
        if (remap_strap && (sys_addr == `REMAP_BASE)) begin
            next_cs_hit[0] = 1'b1;
        end
        next_cs0_at_zero = remap_strap;
        next_shared_addr_data = mux_mode_strap;
        next_sync_bypass_bus = bus_side_sync_strap;
        next_bus_fast_sync = bus_faster_sync_strap;
        next_ebi_in_use = ext_bus_strap;
        next_bus_rst_n = bus_rst_eff;
    end

    // Bus domain state, cleared at once by the low bus reset.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            user_config <= 8'h00;
            user_status_rd <= 8'h00;
            lp_ack <= 1'b0;
            mem_irq <= 1'b0;
            ecc_irq <= 1'b0;
            combined_irq <= 1'b0;
            cs_hit <= 4'h0;
            cs0_width <= 2'h0;
            cs0_width_rsv <= 1'b0;
            cs0_at_zero <= 1'b0;
            shared_addr_data <= 1'b0;
            sync_bypass_bus <= 1'b0;
            bus_fast_sync <= 1'b0;
            ebi_in_use <= 1'b0;
            bus_rst_n <= 1'b0;
        end else begin
            user_config <= next_user_config;
            user_status_rd <= next_user_status_rd;
            lp_ack <= next_lp_ack;
            mem_irq <= next_mem_irq;
            ecc_irq <= next_ecc_irq;
            combined_irq <= next_combined_irq;
            cs_hit <= next_cs_hit;
            cs0_width <= next_cs0_width;
            cs0_width_rsv <= next_cs0_width_rsv;
            cs0_at_zero <= next_cs0_at_zero;
            shared_addr_data <= next_shared_addr_data;
            sync_bypass_bus <= next_sync_bypass_bus;
            bus_fast_sync <= next_bus_fast_sync;
            ebi_in_use <= next_ebi_in_use;
            bus_rst_n <= next_bus_rst_n;
        end
    end

    // ************************************************************************
    // Memory domain: NAND chip select hold on the inverted clock, memory side flags on the true clock
    // ************************************************************************
    nand_phase_e phase;
    nand_phase_e next_phase;
    logic next_nand_cs;

    // Phase tracker; with the hold strap the select spans both phases.
    always_comb begin
        next_phase = phase;
        unique case (phase)
            nand_idle: begin
                if (nand_start) begin
                    next_phase = nand_addr;
                end
            end
            nand_addr: begin
                if (nand_addr_done) begin
                    next_phase = nand_data;
                end
            end
            nand_data: begin
                if (nand_data_done) begin
                    next_phase = nand_idle;
                end
            end
            default: next_phase = nand_idle;
        endcase
        // Without the hold strap the select drops for one edge between the address
        // and the data phase; with it the select stays up for the whole transfer.
        if (nand_cs_hold_strap) begin
            next_nand_cs = (next_phase != nand_idle);
        end else begin
            next_nand_cs = (next_phase != nand_idle) && !(phase == nand_addr && nand_addr_done);
        end
    end

    // NAND outputs registered on the inverted clock edge.
    always_ff @(posedge mem_if0_clk_inv or negedge mem_if0_rst_low) begin
        if (!mem_if0_rst_low) begin
            phase <= nand_idle;
            nand_cs_active <= 1'b0;
        end else begin
            phase <= next_phase;
            nand_cs_active <= next_nand_cs;
        end
    end

    logic next_sync_bypass_mem;
    logic next_mem_rst_n;

    // Memory side flags; the reset output follows the synchronised or bypassed reset.
    always_comb begin
        next_sync_bypass_mem = mem_side_sync_strap;
        next_mem_rst_n = mem_rst_eff;
    end

    // Memory side flags registered on the true memory clock.
    always_ff @(posedge mem_if0_clk or negedge mem_if0_rst_low) begin
        if (!mem_if0_rst_low) begin
            sync_bypass_mem <= 1'b0;
            mem_rst_n <= 1'b0;
        end else begin
            sync_bypass_mem <= next_sync_bypass_mem;
            mem_rst_n <= next_mem_rst_n;
        end
    end

    // ************************************************************************
    // Test clock forwarding
    // ************************************************************************
    // Under the test override the forwarded line is the memory clock itself, so it cannot
    // come from a flop; change the override only while the clock is low to avoid a runt.
    assign mem_clk_out = test_clk_override & mem_if0_clk;

endmodule

// >>> verif/static_mem_strap_and_misc_io_chk.sv
// Concurrent checks on the ports of the strap, reset and user I/O block.
module static_mem_strap_and_misc_io_chk (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic reg_clk_en,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] user_config,
    input wire logic lp_clk_en,
    input wire logic lp_req,
    input wire logic lp_ack,
    input wire logic mem_irq,
    input wire logic ecc_irq,
    input wire logic combined_irq,
    input wire logic is_flash_if,
    input wire logic ecc_present,
    input wire logic mux_mode_strap,
    input wire logic shared_addr_data,
    input wire logic remap_strap,
    input wire logic cs0_at_zero,
    input wire logic rst_bypass,
    input wire logic bus_rst_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // Properties
    // ********
    // Every check runs on the bus clock and rests while the bus reset is low.
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // A write is taken when the register enable and the strobe meet.
    sequence s_wr;
        reg_clk_en && reg_wr;
    endsequence
    AST_CFG_WR: assert property (s_wr |=> user_config == $past(reg_wdata))
        else $error("user_config missed a write");
    AST_CFG_HOLD: assert property (!reg_clk_en |=> $stable(user_config))
        else $error("user_config moved while disabled");
    AST_LP: assert property (lp_clk_en && bus_rst_n |=> lp_ack == $past(lp_req))
        else $error("lp_ack did not follow lp_req");
    AST_IRQ_OR: assert property (combined_irq == (mem_irq | ecc_irq))
        else $error("combined_irq is not the OR");
    AST_ECC_GATE: assert property (!(is_flash_if && ecc_present) |=> !ecc_irq)
        else $error("ecc_irq without flash and ECC");
    AST_MUX: assert property (bus_rst_n |=> shared_addr_data == $past(mux_mode_strap))
        else $error("shared_addr_data wrong");
    AST_REMAP: assert property (bus_rst_n |=> cs0_at_zero == $past(remap_strap))
        else $error("cs0_at_zero wrong");
    AST_BUS_RST: assert property ($rose(bus_rst_n) |-> (rst_bypass ?
        $past(arst_n) && !$past(arst_n, 2) : $past(arst_n, 3) && !$past(arst_n, 4)))
        else $error("bus_rst_n released at the wrong edge");
endmodule

// >>> verif/soc_side_model.sv
// Model of the integrating logic that makes the memory clock and sets integrator straps.
module soc_side_model (
    output logic mem_if0_clk,
    output logic mem_if0_clk_inv,
    output logic bus_faster_sync_strap,
    output logic ext_bus_strap
);
    timeunit 1ns;
    timeprecision 1ps;
    // The memory clock is unrelated to the bus clock and no shared bus exists.
    initial begin
        mem_if0_clk = 1'h0;
        bus_faster_sync_strap = 1'h0;
        ext_bus_strap = 1'h0;
    end
    // A free 30 ns memory clock with its inverse on a line of its own.
    always #15 mem_if0_clk = ~mem_if0_clk;
    assign mem_if0_clk_inv = ~mem_if0_clk;
endmodule

// >>> verif/static_mem_strap_and_misc_io_tb.sv
// Self-checking bench of the strap, reset and user I/O block.
module static_mem_strap_and_misc_io_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'h0, arst_n, mem_if0_clk, mem_if0_clk_inv, mem_if0_rst_low, reg_clk_en;
    logic lp_clk_en, reg_wr, lp_req, mux_mode_strap, remap_strap, is_flash_if, ecc_present;
    logic boot_width_strap_flash, nand_cs_hold_strap, bus_side_sync_strap, mem_side_sync_strap;
    logic bus_faster_sync_strap, ext_bus_strap, mem_event, ecc_event, nand_start, nand_addr_done;
    logic nand_data_done, test_clk_override, rst_bypass, bus_rst_n, mem_rst_n, shared_addr_data;
    logic cs0_at_zero, cs0_width_rsv, sync_bypass_bus, sync_bypass_mem, bus_fast_sync;
    logic ebi_in_use, lp_ack, mem_irq, ecc_irq, combined_irq, nand_cs_active, mem_clk_out;
    logic [1:0] boot_width_strap_static, cs0_width;
    logic [3:0] cs_hit, hit;
    logic [7:0] reg_wdata, user_status, user_config, user_status_rd, last;
    logic [31:0] sys_addr, addr_mask_straps, addr_match_straps;
    logic [7:0] exp_q[$];
    logic wr_taken;
    int seed = 25970;
    int err_count = 0;
    int n_compared = 0;
    static_mem_strap_and_misc_io uut (.*);
    soc_side_model partner (.mem_if0_clk, .mem_if0_clk_inv, .bus_faster_sync_strap, .ext_bus_strap);
    // ********
    // Helpers
    // ********
    always #10 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic do_reset(input logic byp, input int edges);
        int n;
        rst_bypass = byp;
        arst_n = 1'h0;
        mem_if0_rst_low = 1'h0;
        tick(20);
        chk("bus_rst_n low", bus_rst_n, 0);
        chk("mem_rst_n low", mem_rst_n, 0);
        arst_n = 1'h1;
        mem_if0_rst_low = 1'h1;
        n = 0;
        while (bus_rst_n !== 1'h1 && n < 10) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("bus_rst_n edges", n, edges);
        tick(6);
        chk("mem_rst_n", mem_rst_n, 1);
        $display("test reset done");
    endtask
    task automatic nand_step(input int p, input logic hold);
        @(negedge mem_if0_clk_inv);
        {nand_start, nand_addr_done, nand_data_done} = 3'(p);
        @(negedge mem_if0_clk_inv);
        {nand_start, nand_addr_done, nand_data_done} = 3'h0;
        chk("nand_cs_active", nand_cs_active, p == 4 || (p == 2 && hold));
        @(negedge mem_if0_clk_inv);
        chk("nand_cs_settled", nand_cs_active, p > 1);
    endtask
    // Notes whether a write was taken, so that its result is due one cycle later.
    always @(posedge mclk) wr_taken <= reg_wr && reg_clk_en;
    // Takes the oldest noted value when a written result appears.
    always @(negedge mclk) if (wr_taken === 1'h1) begin
        chk("user_config", user_config, exp_q.pop_front());
    end
    // Cuts a hang short well after the two hundred or so cycles the tests need.
    initial begin
        #100us;
        err_count++;
        print_verdict();
    end
    // ********
    // Tests
    // ********
    // Main sequence of scenarios.
    initial begin
        {reg_clk_en, lp_clk_en, reg_wr, reg_wdata, lp_req, mux_mode_strap, remap_strap} = '0;
        {is_flash_if, boot_width_strap_static, boot_width_strap_flash, nand_cs_hold_strap} = '0;
        {ecc_present, sys_addr, addr_mask_straps, addr_match_straps, bus_side_sync_strap} = '0;
        {mem_side_sync_strap, mem_event, ecc_event, nand_start, nand_addr_done} = '0;
        {nand_data_done, user_status, test_clk_override, rst_bypass, arst_n} = '0;
        mem_if0_rst_low = 1'h0;
        last = 8'h00;
        do_reset(1'h0, 3);
        for (int i = 0; i < 12; i++) begin
            reg_wr = 1'h1;
            reg_clk_en = 1'($random(seed));
            reg_wdata = 8'($random(seed));
            if (reg_clk_en) exp_q.push_back(reg_wdata);
            if (reg_clk_en) last = reg_wdata;
            tick(1);
        end
        reg_wr = 1'h0;
        reg_clk_en = 1'h1;
        user_status = 8'($random(seed));
        lp_req = 1'h1;
        tick(2);
        chk("user_config kept", user_config, last);
        chk("user_status_rd", user_status_rd, user_status);
        chk("lp_ack gated", lp_ack, 0);
        lp_clk_en = 1'h1;
        tick(2);
        chk("lp_ack", lp_ack, 1);
        $display("test user io done");
        remap_strap = 1'h1;
        for (int w = 0; w < 6; w++) begin
            is_flash_if = w > 3;
            boot_width_strap_static = 2'(w);
            boot_width_strap_flash = w[0];
            mux_mode_strap = w[0];
            bus_side_sync_strap = w[1];
            mem_side_sync_strap = ~w[1];
            tick(4);
            chk("cs0_width", cs0_width, is_flash_if ? w - 4 : w);
            chk("cs0_width_rsv", cs0_width_rsv, w == 3);
            chk("shared_addr_data", shared_addr_data, w[0]);
            chk("sync bypass", {sync_bypass_bus, sync_bypass_mem}, {w[1], ~w[1]});
        end
        remap_strap = 1'h0;
        for (int k = 0; k < 8; k++) begin
            sys_addr = $random(seed);
            addr_mask_straps = $random(seed);
            addr_match_straps = $random(seed);
            for (int i = 0; i < 4; i++) begin
                if (!i[0]) addr_match_straps[8*i+:8] = sys_addr[31:24] & addr_mask_straps[8*i+:8];
                hit[i] = (sys_addr[31:24] & addr_mask_straps[8*i+:8]) == addr_match_straps[8*i+:8];
            end
            tick(2);
            chk("cs_hit", cs_hit, hit);
        end
        remap_strap = 1'h1;
        sys_addr = '0;
        addr_mask_straps = '1;
        addr_match_straps = '1;
        tick(2);
        chk("cs_hit zero", cs_hit, 4'h1);
        chk("bus_fast_sync", bus_fast_sync, bus_faster_sync_strap);
        chk("ebi_in_use", ebi_in_use, ext_bus_strap);
        remap_strap = 1'h0;
        tick(2);
        chk("cs_hit no remap", cs_hit, 4'h0);
        $display("test straps done");
        for (int c = 0; c < 16; c++) begin
            {is_flash_if, mem_event, ecc_event, ecc_present} = 4'(c);
            tick(2);
            chk("irqs", {mem_irq, ecc_irq}, {c[2], c[3] & c[1] & c[0]});
            chk("combined_irq", combined_irq, c[2] | (c[3] & c[1] & c[0]));
        end
        for (int h = 0; h < 2; h++) begin
            nand_cs_hold_strap = h[0];
            for (int p = 4; p > 0; p >>= 1) begin
                nand_step(p, h[0]);
            end
        end
        test_clk_override = 1'h1;
        @(posedge mem_if0_clk);
        #1;
        chk("mem_clk_out high", mem_clk_out, 1);
        @(negedge mem_if0_clk);
        #1;
        chk("mem_clk_out low", mem_clk_out, 0);
        test_clk_override = 1'h0;
        @(posedge mem_if0_clk);
        #1;
        chk("mem_clk_out off", mem_clk_out, 0);
        $display("test irq and flash done");
        tick(1);
        do_reset(1'h1, 1);
        print_verdict();
    end
endmodule
bind static_mem_strap_and_misc_io static_mem_strap_and_misc_io_chk chk_i (.mclk, .arst_n,
    .reg_clk_en, .reg_wr, .reg_wdata, .user_config, .lp_clk_en, .lp_req, .lp_ack, .mem_irq,
    .ecc_irq, .combined_irq, .is_flash_if, .ecc_present, .mux_mode_strap, .shared_addr_data,
    .remap_strap, .cs0_at_zero, .rst_bypass, .bus_rst_n);
